// ==== hw/amp_serial_control_port.sv ====
// amp_serial_control_port: write-only control port, two-wire or three-wire.
// assumes serial pins are asynchronous; data line open drain, enable high drives low.
// assumes each link phase lasts well over three system clocks, as pins pass two flops.
// reset_n stands in for the power-on defaults; the serial side has no reset of its own.
`timescale 1ns/100ps
`default_nettype none
module amp_serial_control_port
#(
  parameter int ABORT_CYCLES = ascp_pkg::ABORT_CYC
)
(
  input wire logic clk_sys,
  input wire logic reset_n,
  input wire logic serialClock,
  input wire logic serialDataIn,
  output logic serialDataOut,
  output logic serialDataOe,
  input wire logic addr_select_enable_n,
  input wire logic port_protocol_select,
  output logic capless_output_select,
  output logic out_mode_bit2,
  output logic out_mode_bit1,
  output logic out_mode_bit0,
  output logic spatial_enable,
  output logic spatial_width_select,
  output logic spatial_level_lsb,
  output logic spatial_level_msb,
  output logic [4:0] mono_gain_code,
  output logic [4:0] left_gain_code,
  output logic [4:0] right_gain_code,
  output logic output_off,
  output logic speakerOn,
  output logic headphoneOn,
  output logic speakerMonoMix,
  output logic speakerStereoMix,
  output logic headphoneMonoMix,
  output logic headphoneStereo
);
  logic sclLvl;
  logic sclRise;
  logic sclFall;
  logic sdaLvl;
  logic sdaRise;
  logic sdaFall;
  logic enLvl;
  logic enRise;
  logic selLvl;
  ascp_sync u_scl
  (
    .clk_sys(clk_sys),
    .reset_n(reset_n),
    .din(serialClock),
    .resetValue(1'b1),
    .dout(sclLvl),
    .rise(sclRise),
    .fall(sclFall)
  );
  ascp_sync u_sda
  (
    .clk_sys(clk_sys),
    .reset_n(reset_n),
    .din(serialDataIn),
    .resetValue(1'b1),
    .dout(sdaLvl),
    .rise(sdaRise),
    .fall(sdaFall)
  );
  ascp_sync u_en
  (
    .clk_sys(clk_sys),
    .reset_n(reset_n),
    .din(addr_select_enable_n),
    .resetValue(1'b1),
    .dout(enLvl),
    .rise(enRise),
    .fall()
  );
  ascp_sync u_sel
  (
    .clk_sys(clk_sys),
    .reset_n(reset_n),
    .din(port_protocol_select),
    .resetValue(1'b1),
    .dout(selLvl),
    .rise(),
    .fall()
  );

  wire logic spiMode = selLvl;
  wire logic startCond = ~spiMode & sclLvl & sdaFall;
  wire logic stopCond = ~spiMode & sclLvl & sdaRise;

  ascp_pkg::ascp_state_t state;
  ascp_pkg::ascp_state_t next_state;
  logic [7:0] shift;
  logic [3:0] bitCount;
  logic ackDrive;
  logic [7:0] spiShift;
  logic [3:0] spiCount;
  logic [15:0] enHighCnt;

  // two-wire byte assembly
  wire logic [7:0] shiftNext = {shift[6:0], sdaLvl};
  wire logic byteDone = sclRise && (bitCount == 4'd7);
  wire logic [7:0] ownAddr = {ascp_pkg::DEV_ADDR_HI, enLvl, 1'b0};
  wire logic addrMatch = (shiftNext == ownAddr);
  wire logic i2cLoad = (state == ascp_pkg::ASCP_DATA) && byteDone;
  // three-wire: apply on enable rise only with eight bits, extra clocks ignored
  wire logic spiLoad = spiMode && enRise && (spiCount == 4'd8);
  wire logic doLoad = i2cLoad | spiLoad;
  wire logic [7:0] loadByte = i2cLoad ? shiftNext : spiShift;

  always_comb
  begin
    next_state = state;
    case (state)
      ascp_pkg::ASCP_IDLE: next_state = state;
      ascp_pkg::ASCP_ADDR:
        if (byteDone)
          next_state = addrMatch ? ascp_pkg::ASCP_AACK : ascp_pkg::ASCP_SKIP;
      ascp_pkg::ASCP_AACK:
        if (sclFall && ackDrive)
          next_state = ascp_pkg::ASCP_DATA;
      ascp_pkg::ASCP_DATA:
        if (byteDone)
          next_state = ascp_pkg::ASCP_DACK;
      ascp_pkg::ASCP_DACK:
        if (sclFall && ackDrive)
          next_state = ascp_pkg::ASCP_DATA;
      ascp_pkg::ASCP_SKIP: next_state = state;
      default: next_state = ascp_pkg::ASCP_IDLE;
    endcase
    if (startCond)
      next_state = ascp_pkg::ASCP_ADDR;
    else if (stopCond || spiMode)
      next_state = ascp_pkg::ASCP_IDLE;
  end

  always_ff @(posedge clk_sys or negedge reset_n)
  begin
    if (!reset_n)
      state <= ascp_pkg::ASCP_IDLE;
    else
      state <= next_state;
  end

  // the bit counter runs only in the address and data phases
  wire logic countBit = sclRise
    && (state == ascp_pkg::ASCP_ADDR || state == ascp_pkg::ASCP_DATA);
  always_ff @(posedge clk_sys or negedge reset_n)
  begin
    if (!reset_n)
      bitCount <= 4'h0;
    else if (startCond || byteDone)
      bitCount <= 4'h0;
    else if (countBit)
      bitCount <= bitCount + 4'h1;
  end

  always_ff @(posedge clk_sys or negedge reset_n)
  begin
    if (!reset_n)
      shift <= 8'h00;
    else if (sclRise)
      shift <= shiftNext;
  end

  // drive ack from the falling edge after the eighth bit to the next fall
  wire logic ackClear = startCond || stopCond || spiMode;
  wire logic ackSlot = (next_state == ascp_pkg::ASCP_AACK)
    || (next_state == ascp_pkg::ASCP_DACK);
  always_ff @(posedge clk_sys or negedge reset_n)
  begin
    if (!reset_n)
      ackDrive <= 1'b0;
    else if (ackClear)
      ackDrive <= 1'b0;
    else if (sclFall && ackSlot && !ackDrive)
      ackDrive <= 1'b1;
    else if (sclFall)
      ackDrive <= 1'b0;
  end

  assign serialDataOut = 1'b0;
  assign serialDataOe = ackDrive;

  // three-wire shifter
  wire logic enTimedOut = enHighCnt >= 16'(ABORT_CYCLES);
  always_ff @(posedge clk_sys or negedge reset_n)
  begin
    if (!reset_n)
      enHighCnt <= 16'h0000;
    else if (!enLvl)
      enHighCnt <= 16'h0000;
    else if (!enTimedOut)
      enHighCnt <= enHighCnt + 16'h0001;
  end

  // a cut byte is dropped once enable has stood high for the abort count
  always_ff @(posedge clk_sys or negedge reset_n)
  begin
    if (!reset_n)
    begin
      spiShift <= 8'h00;
      spiCount <= 4'h0;
    end
    else
    begin
      if (!spiMode || (enLvl && enTimedOut))
        spiCount <= 4'h0;
      else if (spiLoad)
        spiCount <= 4'h0;
      else if (!enLvl && sclRise && spiCount != 4'd8)
      begin
        spiShift <= {spiShift[6:0], sdaLvl};
        spiCount <= spiCount + 4'h1;
      end
    end
  end

  // control registers
  wire logic hitMode = (loadByte[7:4] == ascp_pkg::SEL_MODE);
  wire logic hitSpatial = (loadByte[7:4] == ascp_pkg::SEL_SPATIAL);
  wire logic hitMono = (loadByte[7:5] == ascp_pkg::SEL_MONO);
  wire logic hitLeft = (loadByte[7:5] == ascp_pkg::SEL_LEFT);
  wire logic hitRight = (loadByte[7:5] == ascp_pkg::SEL_RIGHT);
  logic [3:0] modeReg;
  logic [3:0] spatialReg;
  always_ff @(posedge clk_sys or negedge reset_n)
  begin
    if (!reset_n)
    begin
      modeReg <= ascp_pkg::MODE_RESET;
      spatialReg <= ascp_pkg::SPATIAL_RESET;
    end
    else if (doLoad)
    begin
      // other patterns fall through untouched
      if (hitMode)
        modeReg <= loadByte[3:0];
      if (hitSpatial)
        spatialReg <= loadByte[3:0];
    end
  end

  // gain code passes straight to the analog ladder; -54dB at 0, +18dB at 31
  always_ff @(posedge clk_sys or negedge reset_n)
  begin
    if (!reset_n)
    begin
      mono_gain_code <= ascp_pkg::GAIN_RESET;
      left_gain_code <= ascp_pkg::GAIN_RESET;
      right_gain_code <= ascp_pkg::GAIN_RESET;
    end
    else if (doLoad)
    begin
      if (hitMono)
        mono_gain_code <= loadByte[4:0];
      if (hitLeft)
        left_gain_code <= loadByte[4:0];
      if (hitRight)
        right_gain_code <= loadByte[4:0];
    end
  end

  assign capless_output_select = modeReg[ascp_pkg::OCL_BIT];
  assign out_mode_bit2 = modeReg[2];
  assign out_mode_bit1 = modeReg[1];
  assign out_mode_bit0 = modeReg[0];
  assign spatial_enable = spatialReg[ascp_pkg::SP_EN_BIT];
  assign spatial_width_select = spatialReg[ascp_pkg::SP_WIDTH_BIT];
  assign spatial_level_lsb = spatialReg[ascp_pkg::SP_LVL_LSB];
  assign spatial_level_msb = spatialReg[ascp_pkg::SP_LVL_LSB + 1];

  // path enables follow the stored mode code with no extra register stage
  ascp_decode u_dec
  (
    .modeCode(modeReg[2:0]),
    .spkOn(speakerOn),
    .hpOn(headphoneOn),
    .spkMonoMix(speakerMonoMix),
    .spkStereoMix(speakerStereoMix),
    .hpMonoMix(headphoneMonoMix),
    .hpStereo(headphoneStereo),
    .outputOff(output_off)
  );
endmodule
`default_nettype wire

// ==== hw/ascp_pkg.sv ====
// ascp_pkg: constants of the amplifier serial control port.
// assumes a 250 MHz system clock sampling the serial pins.
package ascp_pkg;
  localparam int CLK_MHZ = 250;
  // enable-high time after which a partial byte is dropped
  localparam int ABORT_NS = 100;
  localparam int ABORT_CYC = (ABORT_NS * CLK_MHZ + 999) / 1000;
  localparam logic [5:0] DEV_ADDR_HI = 6'h3e;
  localparam logic [3:0] SEL_MODE = 4'h0;
  localparam logic [3:0] SEL_SPATIAL = 4'h4;
  localparam logic [2:0] SEL_MONO = 3'h4;
  localparam logic [2:0] SEL_LEFT = 3'h6;
  localparam logic [2:0] SEL_RIGHT = 3'h7;
  localparam int OCL_BIT = 3;
  localparam int SP_EN_BIT = 0;
  localparam int SP_WIDTH_BIT = 1;
  localparam int SP_LVL_LSB = 2;
  localparam logic [3:0] MODE_RESET = 4'h0;
  localparam logic [3:0] SPATIAL_RESET = 4'h0;
  localparam logic [4:0] GAIN_RESET = 5'h13;
  localparam logic [2:0] OM_SHUTDOWN = 3'h0;
  localparam logic [2:0] OM_SPK_MONO = 3'h1;
  localparam logic [2:0] OM_HP_MONO = 3'h2;
  localparam logic [2:0] OM_SPK_LR = 3'h3;
  localparam logic [2:0] OM_HP_STEREO = 3'h4;
  localparam logic [2:0] OM_SPK_LRM = 3'h5;
  localparam logic [2:0] OM_HP_STM = 3'h6;
  localparam logic [2:0] OM_ALL_ST = 3'h7;
  typedef enum {ASCP_IDLE, ASCP_ADDR, ASCP_AACK, ASCP_DATA, ASCP_DACK, ASCP_SKIP} ascp_state_t;
endpackage

// ==== hw/ascp_sync.sv ====
// ascp_sync: two-flop synchroniser with edge flags from the second stage.
// assumes din is asynchronous to clk_sys.
`timescale 1ns/100ps
`default_nettype none
module ascp_sync
(
  input wire logic clk_sys,
  input wire logic reset_n,
  input wire logic din,
  input wire logic resetValue,
  output logic dout,
  output logic rise,
  output logic fall
);
  logic meta;
  logic stage;
  logic last;
  always_ff @(posedge clk_sys or negedge reset_n)
  begin
    if (!reset_n)
    begin
      meta <= 1'b1;
      stage <= 1'b1;
      last <= 1'b1;
    end
    else
    begin
      meta <= din;
      stage <= meta;
      last <= stage;
    end
  end
  // resetValue unused by design of flops; keeps port list uniform
  wire unusedReset = resetValue;
  assign dout = stage;
  assign rise = stage & ~last;
  assign fall = ~stage & last;
endmodule
`default_nettype wire

// ==== hw/ascp_decode.sv ====
// ascp_decode: turns the stored output-mode code into path enables.
// assumes mode code from the control register.
`timescale 1ns/100ps
`default_nettype none
module ascp_decode
(
  input wire logic [2:0] modeCode,
  output logic spkOn,
  output logic hpOn,
  output logic spkMonoMix,
  output logic spkStereoMix,
  output logic hpMonoMix,
  output logic hpStereo,
  output logic outputOff
);
  wire logic [2:0] m = modeCode;
  assign outputOff = (m == ascp_pkg::OM_SHUTDOWN);
  assign spkMonoMix = (m == ascp_pkg::OM_SPK_MONO) || (m == ascp_pkg::OM_SPK_LRM);
  assign spkStereoMix = (m == ascp_pkg::OM_SPK_LR) || (m == ascp_pkg::OM_SPK_LRM)
    || (m == ascp_pkg::OM_ALL_ST);
  assign hpMonoMix = (m == ascp_pkg::OM_HP_MONO) || (m == ascp_pkg::OM_HP_STM);
  assign hpStereo = (m == ascp_pkg::OM_HP_STEREO) || (m == ascp_pkg::OM_HP_STM)
    || (m == ascp_pkg::OM_ALL_ST);
  assign spkOn = spkMonoMix | spkStereoMix;
  assign hpOn = hpMonoMix | hpStereo;
endmodule
`default_nettype wire

// ==== verif/ascp_asserts.sv ====
// ascp_asserts: port-level properties of the serial control port.
// assumes binding onto amp_serial_control_port, one clock domain.
`timescale 1ns/100ps
`default_nettype none
module ascp_asserts
(
  input wire logic clk_sys,
  input wire logic reset_n,
  input wire logic serialClock,
  input wire logic serialDataOut,
  input wire logic serialDataOe,
  input wire logic addr_select_enable_n,
  input wire logic port_protocol_select,
  input wire logic out_mode_bit2,
  input wire logic out_mode_bit1,
  input wire logic out_mode_bit0,
  input wire logic [4:0] left_gain_code,
  input wire logic output_off,
  input wire logic speakerOn,
  input wire logic headphoneOn,
  input wire logic headphoneStereo
);
  wire logic [2:0] mode = {out_mode_bit2, out_mode_bit1, out_mode_bit0};
  default clocking cb @(posedge clk_sys);
  endclocking
  default disable iff (!reset_n);
  chk_off_decode: assert property (output_off == (mode == 3'h0))
    else $error("shutdown flag disagrees with mode");
  chk_spk_mono: assert property (mode == 3'h1 |-> speakerOn && !headphoneOn)
    else $error("mode 1 paths wrong");
  chk_hp_mono: assert property (mode == 3'h2 |-> !speakerOn && headphoneOn)
    else $error("mode 2 paths wrong");
  chk_hp_stereo: assert property (mode == 3'h4 |-> !speakerOn && headphoneStereo)
    else $error("mode 4 paths wrong");
  chk_all_stereo: assert property (mode == 3'h7 |-> speakerOn && headphoneStereo)
    else $error("mode 7 paths wrong");
  chk_ack_slot: assert property ($rose(serialDataOe) |-> !serialClock && !port_protocol_select)
    else $error("acknowledge outside a low clock slot");
  chk_ack_width: assert property ($rose(serialDataOe) |-> serialDataOe[*4] ##[1:400] !serialDataOe)
    else $error("acknowledge pulse length wrong");
  chk_spi_latch: assert property (port_protocol_select && $past(port_protocol_select, 8)
    && $changed(left_gain_code) |-> addr_select_enable_n)
    else $error("register changed while enable low");
  chk_drive_low: assert property ($fell(serialDataOe) |-> !serialClock && serialDataOut == 1'b0)
    else $error("acknowledge released outside a low clock phase");
  cover property (mode == 3'h7);
  cover property ($rose(serialDataOe));
  cover property (port_protocol_select && $changed(left_gain_code));
endmodule
bind amp_serial_control_port ascp_asserts u_ascp_asserts (.*);
`default_nettype wire

// ==== verif/ascp_host.sv ====
// ascp_host: host controller model, two-wire and three-wire writes.
// assumes dataWire is the resolved data line; clock half period 6 cycles.
`timescale 1ns/100ps
`default_nettype none
module ascp_host
(
  input wire logic clk_sys,
  input wire logic dataWire,
  output logic sclk,
  output logic sdaDrv,
  output logic enN,
  output logic sel
);
  initial
  begin
    sclk = 1'b1;
    sdaDrv = 1'b1;
    enN = 1'b1;
    sel = 1'b0;
  end
  // bench link runs fast to keep runs short; a real host stays within the two-wire rate
  task automatic half();
    repeat (6) @(posedge clk_sys);
  endtask
  // address-select level for two-wire; waits until the port has seen it
  task automatic setId(input logic v);
    enN <= v;
    repeat (10) @(posedge clk_sys);
  endtask
  // clock idles high for two-wire, low for three-wire
  task automatic useSpi(input logic s);
    sel <= s;
    sclk <= !s;
    sdaDrv <= 1'b1;
    repeat (10) @(posedge clk_sys);
  endtask
  task automatic i2cStart();
    half();
    sdaDrv <= 1'b0;
    half();
    sclk <= 1'b0;
    repeat (2) @(posedge clk_sys);
  endtask
  // eight bits then a released slot; ack is set when the line is seen low in that slot
  task automatic i2cByte(input logic [7:0] b, output logic ack);
    logic [8:0] bits;
    bits = {b, 1'b1};
    for (int i = 8; i >= 0; i--)
    begin
      sdaDrv <= bits[i];
      half();
      sclk <= 1'b1;
      half();
      ack = !dataWire;
      sclk <= 1'b0;
      repeat (2) @(posedge clk_sys);
    end
  endtask
  task automatic i2cStop();
    sdaDrv <= 1'b0;
    half();
    sclk <= 1'b1;
    half();
    sdaDrv <= 1'b1;
    half();
  endtask
  // sends the n leading bits of v; data toggles once released
  task automatic spiBits(input logic [15:0] v, input int n);
    enN <= 1'b0;
    half();
    for (int i = 15; i > 15 - n; i--)
    begin
      sdaDrv <= v[i];
      half();
      sclk <= 1'b1;
      half();
      sclk <= 1'b0;
    end
    half();
    enN <= 1'b1;
    sdaDrv <= ~sdaDrv;
    repeat (30) @(posedge clk_sys);
  endtask
endmodule
`default_nettype wire

// ==== verif/tb_amp_serial_control_port.sv ====
// tb_amp_serial_control_port: directed writes over both protocols.
// assumes open-drain data line with pull-up, host model drives pins.
`timescale 1ns/100ps
`default_nettype none
module tb_amp_serial_control_port;
  localparam logic [6:0] PATHS [8] = '{7'h40, 7'h28, 7'h12, 7'h24, 7'h11, 7'h2c, 7'h13, 7'h35};
  logic clk_sys = 1'b0;
  logic reset_n = 1'b0;
  logic ack;
  int n_errors = 0;
  int comparisons = 0;
  wire logic serialClock, serialDataIn, serialDataOut, serialDataOe, sdaDrv;
  wire logic addr_select_enable_n, port_protocol_select, capless_output_select;
  wire logic out_mode_bit2, out_mode_bit1, out_mode_bit0, spatial_enable, output_off;
  wire logic spatial_width_select, spatial_level_lsb, spatial_level_msb;
  wire logic speakerOn, headphoneOn, speakerMonoMix, speakerStereoMix;
  wire logic headphoneMonoMix, headphoneStereo;
  wire logic [4:0] mono_gain_code, left_gain_code, right_gain_code;
  wire logic [7:0] mReg = {4'h0, capless_output_select, out_mode_bit2, out_mode_bit1,
    out_mode_bit0};
  wire logic [7:0] sReg = {4'h4, spatial_level_msb, spatial_level_lsb, spatial_width_select,
    spatial_enable};
  wire logic [7:0] paths = {1'b0, output_off, speakerOn, headphoneOn, speakerMonoMix,
    speakerStereoMix, headphoneMonoMix, headphoneStereo};
  assign serialDataIn = sdaDrv & !serialDataOe;
  amp_serial_control_port u_amp_serial_control_port (.*);
  ascp_host u_ascp_host (.clk_sys, .dataWire(serialDataIn), .sclk(serialClock), .sdaDrv,
    .enN(addr_select_enable_n), .sel(port_protocol_select));
  always #2 clk_sys = ~clk_sys;
  task automatic chk(input string what, input logic [7:0] seen, input logic [7:0] exp);
    comparisons++;
    if (seen !== exp)
    begin
      n_errors++;
      $display("[ERR] %s expected %h seen %h", what, exp, seen);
    end
  endtask
  task automatic chkAll(input logic [7:0] m, s, mo, l, r);
    chk("mode", mReg, m);
    chk("spatial", sReg, s);
    chk("mono", {3'h4, mono_gain_code}, mo);
    chk("left", {3'h6, left_gain_code}, l);
    chk("right", {3'h7, right_gain_code}, r);
  endtask
  task automatic results();
    if (n_errors == 0 && comparisons > 0)
      $display("[ PASS ]");
    else
      $display("[ FAIL ]");
    $finish;
  endtask
  task automatic t_reset();
    chkAll(8'h00, 8'h40, {3'h4, ascp_pkg::GAIN_RESET}, {3'h6, ascp_pkg::GAIN_RESET},
      {3'h7, ascp_pkg::GAIN_RESET});
    chk("paths", paths, {1'b0, PATHS[0]});
  endtask
  // one addressed transfer carrying all five registers back to back
  task automatic t_i2c();
    logic [7:0] bytes [5] = '{8'h0b, 8'h4d, 8'h9f, 8'hc0, 8'he5};
    u_ascp_host.useSpi(1'b0);
    u_ascp_host.i2cStart();
    u_ascp_host.i2cByte(8'hfa, ack);
    chk("addr ack", {7'h0, ack}, 8'h01);
    foreach (bytes[k])
    begin
      u_ascp_host.i2cByte(bytes[k], ack);
      chk("data ack", {7'h0, ack}, 8'h01);
    end
    u_ascp_host.i2cStop();
    chkAll(8'h0b, 8'h4d, 8'h9f, 8'hc0, 8'he5);
  endtask
  task automatic t_i2c_foreign();
    u_ascp_host.i2cStart();
    u_ascp_host.i2cByte(8'hf8, ack);
    chk("foreign ack", {7'h0, ack}, 8'h00);
    u_ascp_host.i2cByte(8'h07, ack);
    chk("skipped ack", {7'h0, ack}, 8'h00);
    u_ascp_host.i2cStop();
    chkAll(8'h0b, 8'h4d, 8'h9f, 8'hc0, 8'he5);
    u_ascp_host.setId(1'b0);
    u_ascp_host.i2cStart();
    u_ascp_host.i2cByte(8'hf8, ack);
    chk("low id ack", {7'h0, ack}, 8'h01);
    u_ascp_host.i2cByte(8'h8a, ack);
    u_ascp_host.i2cStop();
    u_ascp_host.setId(1'b1);
    chk("mono", {3'h4, mono_gain_code}, 8'h8a);
  endtask
  task automatic t_spi_modes();
    logic [7:0] mb;
    logic [7:0] sb;
    u_ascp_host.useSpi(1'b1);
    for (int i = 0; i < 8; i++)
    begin
      mb = {4'h0, i[0], i[2:0]};
      sb = {4'h4, i[1:0], i[2], i[0]};
      u_ascp_host.spiBits({mb, 8'h00}, 8);
      u_ascp_host.spiBits({sb, 8'h00}, 8);
      chk("mode", mReg, mb);
      chk("spatial", sReg, sb);
      chk("paths", paths, {1'b0, PATHS[i]});
    end
  endtask
  // short byte, unmatched patterns, then an over-long byte
  task automatic t_spi_faults();
    u_ascp_host.spiBits(16'h9a00, 5);
    u_ascp_host.spiBits(16'h2000, 8);
    u_ascp_host.spiBits(16'h5c00, 8);
    u_ascp_host.spiBits(16'hd1ff, 12);
    chkAll(8'h0f, 8'h4f, 8'h8a, 8'hd1, 8'he5);
  endtask
  initial
  begin
    repeat (2) @(posedge clk_sys);
    reset_n <= 1'b1;
    repeat (4) @(posedge clk_sys);
    t_reset();
    t_i2c();
    t_i2c_foreign();
    t_spi_modes();
    t_spi_faults();
    results();
  end
  // whole run needs about 4200 cycles
  initial
  begin
    repeat (40000) @(posedge clk_sys);
    n_errors++;
    results();
  end
endmodule
`default_nettype wire
